// ===== core/svbc_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by the register bank only
// Notes:   Offsets are word indices; byte address is four times each
`ifndef SVBC_CONSTS_SVH
`define SVBC_CONSTS_SVH

// Word indices of the bank, first to last
`define SVBC_IDX_Q3W_ADMIT     10'h027
`define SVBC_IDX_VID_P0        10'h028
`define SVBC_IDX_TIMER_VID_P1  10'h029
`define SVBC_IDX_TAGSKIP_P2    10'h02A
`define SVBC_IDX_VID_P3_P4     10'h02B
`define SVBC_IDX_MCAST_P5      10'h02C
`define SVBC_IDX_PHY_CTRL      10'h02D
`define SVBC_IDX_ETHERTYPE     10'h02E
`define SVBC_IDX_RESTART       10'h02F
`define SVBC_IDX_MISC          10'h030
`define SVBC_IDX_BW_LIMIT0     10'h031
`define SVBC_IDX_BW_LIMIT1     10'h032
`define SVBC_IDX_BW_ENABLES    10'h033
`define SVBC_NUM_REGS          13

// Reset values
`define SVBC_RST_Q3W_ADMIT     16'h1000
`define SVBC_RST_TAGSKIP_P2    16'h3F00
`define SVBC_RST_MCAST_P5      16'hD000
`define SVBC_RST_PHY_CTRL      16'h4442
`define SVBC_RST_MISC          16'h0987
`define SVBC_RST_ZERO          16'h0000

// Field positions
`define SVBC_F_TIMER_LO        9
`define SVBC_F_BP_EXIT         8
`define SVBC_F_TAGSKIP_LO      8
`define SVBC_F_MCAST_LO        12
`define SVBC_F_CHIPID_DIS      15
`define SVBC_F_P4_LED          12
`define SVBC_F_DUAL_LED        9
`define SVBC_F_DROP            8
`define SVBC_F_TAG_BYPASS      7
`define SVBC_F_CLONE_W         5
`define SVBC_F_P4_CLK_INV      15
`define SVBC_F_CRS_LEN_DIS     14
`define SVBC_F_NEW_RATE_EN     12

// Rate timer intervals in ns, clock period in ns
`define SVBC_CLK_NS            4
`define SVBC_T8MS_NS           8000000
`define SVBC_T1MS_NS           1000000
`define SVBC_T40US_NS          40000
`define SVBC_T500US_NS         500000

// Rate step per timer code, in kbit/s
`define SVBC_STEP_8MS          10'h040
`define SVBC_STEP_1MS          10'h200
`define SVBC_STEP_40US         10'h0C8
`define SVBC_STEP_500US        10'h010

`endif

// ===== core/svbc_pkg.sv
// Purpose: Types used by the register bank only
// Assumes: Constants come from svbc_consts.svh
// Notes:   All bank state travels as one packed struct
package svbc_pkg;

    // Rate timer select codes
    typedef enum logic [1:0] {
        SVBC_TMR_8MS, SVBC_TMR_1MS, SVBC_TMR_40US, SVBC_TMR_500US
    } svbc_timer_t;

    // Whole state of the bank
    typedef struct packed {
        logic [12:0][15:0] regs;      // Stored register words
        logic [31:0]       rdata;     // APB read data
        logic              ready;     // APB ready
        logic              slverr;    // APB error
        logic              restart;   // PHY restart pulse
        logic              crs_on;    // Carrier length check active
        logic [5:0]        rx_en;     // Effective receive limit enables
        logic [5:0]        tx_en;     // Effective transmit limit enables
        logic [20:0]       tick_cnt;  // Rate interval down counter
        logic              tick;      // Rate interval pulse
        logic [9:0]        step;      // Rate step in kbit/s
    } svbc_state_t;

endpackage

// ===== core/svbc_regs.sv
// Purpose: VLAN, tag and bandwidth configuration bank on APB
// Assumes: Single 250 MHz clock; APB master on the same clock
// Notes:   16-bit registers in the low half of each 32-bit word
//
// Behaviour
// [RQ1] Per-port drop of frames without VLAN ID
// [RQ2] Per-port fallback to port-based VLAN
// [RQ3] Four-bit queue three scheduler weight
// [RQ4] Per-port default VID bits eleven to four
// [RQ5] Timer select sets interval and rate step
// [RQ6] Back pressure exits on carrier or data-valid
// [RQ7] Per-port egress tag rule bypass
// [RQ8] Four reserved multicast action bits
// [RQ9] Chip ID check on long management accesses
// [RQ10] Programmable special tag Ether-Type
// [RQ11] Any restart write restarts all PHYs
// [RQ12] Dual speed hub collision LED mode
// [RQ13] Drop frames from PAUSE-ignoring partners
// [RQ14] Skip all tag insert and removal
// [RQ15] MAC clone one or two bit width
// [RQ16] Low four bits of bandwidth maxima
// [RQ17] Invert port four PCS clock
// [RQ18] Carrier length check, active when zero
// [RQ19] Global enable of new bandwidth control
// [RQ20] Per-direction enables gate the limit fields
// [RQ21] Reserved bits store and return values
`timescale 1ns/100ps
`include "svbc_consts.svh"

module svbc_regs
    import svbc_pkg::*;
#(
    // Rate interval lengths in clock cycles
    parameter int CYC_8MS   = `SVBC_T8MS_NS / `SVBC_CLK_NS,
    parameter int CYC_1MS   = `SVBC_T1MS_NS / `SVBC_CLK_NS,
    parameter int CYC_40US  = `SVBC_T40US_NS / `SVBC_CLK_NS,
    parameter int CYC_500US = `SVBC_T500US_NS / `SVBC_CLK_NS
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // VLAN admission and forwarding
    output logic      [5:0]        admit_tagged_only,
    output logic      [5:0]        revert_to_port_vlan,
    output logic      [3:0]        queue_three_weight,
    output logic      [5:0][7:0]   port_vid_upper,
    output logic      [5:0]        egress_tag_skip_enable,
    output logic      [3:0]        reserved_mcast_action,
    output logic      [15:0]       special_tag_ethertype,
    // MAC, PHY and LED options
    output logic                   backpressure_exit_select,
    output logic                   chip_id_check_disable,
    output logic                   phy_restart,
    output logic                   port4_led_mode,
    output logic                   dual_speed_hub_led_enable,
    output logic                   drop_unpaced_frames,
    output logic                   tag_bypass_enable,
    output logic                   mac_clone_width_select,
    output logic                   invert_port4_pcs_clock,
    output logic                   carrier_length_check_on,
    // Bandwidth control
    output logic      [1:0]        rate_timer_select,
    output logic                   new_rate_limit_enable,
    output logic      [5:0][3:0]   rx_limit_low,
    output logic      [1:0][3:0]   tx_limit_low,
    output logic      [5:0]        rx_limit_enable,
    output logic      [5:0]        tx_limit_enable,
    output logic                   rate_tick,
    output logic      [9:0]        rate_step_kbps
);

    // Positions inside the register array
    localparam int R_Q3W  = 0;
    localparam int R_TMR  = 2;
    localparam int R_SKIP = 3;
    localparam int R_MC   = 5;
    localparam int R_PHY  = 6;
    localparam int R_ET   = 7;
    localparam int R_RST  = 8;
    localparam int R_MISC = 9;
    localparam int R_BW0  = 10;
    localparam int R_BW1  = 11;
    localparam int R_BWE  = 12;

    // Refuse interval lengths the 21-bit counter cannot hold
    initial begin
        if (CYC_8MS < 1 || CYC_8MS > 2097152 ||
            CYC_1MS < 1 || CYC_1MS > 2097152 ||
            CYC_40US < 1 || CYC_40US > 2097152 ||
            CYC_500US < 1 || CYC_500US > 2097152) begin
            $error("svbc_regs: interval length out of range");
        end
    end

    // Reset image of the whole state
    localparam svbc_state_t RST_STATE = '{
        regs: {`SVBC_RST_ZERO, `SVBC_RST_ZERO, `SVBC_RST_ZERO,
               `SVBC_RST_MISC, `SVBC_RST_ZERO, `SVBC_RST_ZERO,
               `SVBC_RST_PHY_CTRL, `SVBC_RST_MCAST_P5,
               `SVBC_RST_ZERO, `SVBC_RST_TAGSKIP_P2,
               `SVBC_RST_ZERO, `SVBC_RST_ZERO, `SVBC_RST_Q3W_ADMIT},
        rdata:    32'h0000_0000,
        ready:    1'b0,
        slverr:   1'b0,
        restart:  1'b0,
        crs_on:   1'b1,
        rx_en:    6'h00,
        tx_en:    6'h00,
        tick_cnt: 21'h00_0000,
        tick:     1'b0,
        step:     `SVBC_STEP_8MS
    };

    svbc_state_t state_reg;    // Registered state
    svbc_state_t state_next;   // Next state
    logic [9:0]  word_idx;     // Word index from the byte address
    logic [9:0]  rel_idx;      // Index relative to the first word
    logic        hit;          // Address inside the bank, aligned
    logic        setup;        // APB setup cycle
    logic        wr_take;      // Write committed this edge
    logic [15:0] wr_mask;      // Byte lanes written
    logic [15:0] bwe_next;     // Enable word after any write
    logic [20:0] tick_load;    // Reload for the interval counter

    // Address decode; byte address is four times the word index
    assign word_idx = paddr[11:2];
    assign rel_idx  = word_idx - `SVBC_IDX_Q3W_ADMIT;
    assign hit      = (paddr[1:0] == 2'h0) &&
                      (word_idx >= `SVBC_IDX_Q3W_ADMIT) &&
                      (word_idx <= `SVBC_IDX_BW_ENABLES);
    assign setup    = psel && !penable;
    // Writes land only at the edge where ready is seen high
    assign wr_take  = psel && penable && pwrite && state_reg.ready &&
                      hit;
    assign wr_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Interval length from the timer select code
    always_comb begin
        // [RQ5] interval per code
        case (svbc_timer_t'(state_reg.regs[R_TMR][10:9]))
            SVBC_TMR_8MS:   tick_load = 21'(CYC_8MS - 1);
            SVBC_TMR_1MS:   tick_load = 21'(CYC_1MS - 1);
            SVBC_TMR_40US:  tick_load = 21'(CYC_40US - 1);
            SVBC_TMR_500US: tick_load = 21'(CYC_500US - 1);
            default:        tick_load = 21'(CYC_8MS - 1);
        endcase
    end

    // Next state: bus answer, register writes, derived controls
    always_comb begin
        state_next         = state_reg;
        state_next.restart = 1'b0;
        state_next.tick    = 1'b0;
        bwe_next           = state_reg.regs[R_BWE];

        // Answer registered in setup, so ready rises in the access cycle
        state_next.ready  = setup;
        state_next.slverr = setup && !hit;
        if (setup && hit && !pwrite) begin
            state_next.rdata = {16'h0000, state_reg.regs[rel_idx[3:0]]};
        end else if (setup) begin
            state_next.rdata = 32'h0000_0000;
        end

        // Byte-lane writes; reserved bits are kept like any other
        if (wr_take) begin
            // [RQ21] reserved bits stored
            state_next.regs[rel_idx[3:0]] =
                (state_reg.regs[rel_idx[3:0]] & ~wr_mask) |
                (pwdata[15:0] & wr_mask);
            if (rel_idx[3:0] == 4'(R_BWE)) begin
                bwe_next = state_next.regs[R_BWE];
            end
            // [RQ11] any write restarts
            if (rel_idx[3:0] == 4'(R_RST)) begin
                state_next.restart = 1'b1;
            end
        end

        // [RQ18] inverted check polarity
        state_next.crs_on =
            !state_next.regs[R_BWE][`SVBC_F_CRS_LEN_DIS];

        // [RQ19] global enable gates all
        // [RQ20] per-direction limit enables
        state_next.rx_en = {bwe_next[8], bwe_next[7], bwe_next[6],
                            bwe_next[4], bwe_next[2], bwe_next[0]} &
                           {6{bwe_next[`SVBC_F_NEW_RATE_EN]}};
        state_next.tx_en = {bwe_next[11], bwe_next[10], bwe_next[9],
                            bwe_next[5], bwe_next[3], bwe_next[1]} &
                           {6{bwe_next[`SVBC_F_NEW_RATE_EN]}};

        // [RQ5] rate step per code
        case (svbc_timer_t'(state_reg.regs[R_TMR][10:9]))
            SVBC_TMR_8MS:   state_next.step = `SVBC_STEP_8MS;
            SVBC_TMR_1MS:   state_next.step = `SVBC_STEP_1MS;
            SVBC_TMR_40US:  state_next.step = `SVBC_STEP_40US;
            SVBC_TMR_500US: state_next.step = `SVBC_STEP_500US;
            default:        state_next.step = `SVBC_STEP_8MS;
        endcase

        // Interval counter idles while the scheme is off
        if (!state_reg.regs[R_BWE][`SVBC_F_NEW_RATE_EN]) begin
            state_next.tick_cnt = 21'h00_0000;
        end else if (state_reg.tick_cnt == 21'h00_0000) begin
            // [RQ5] interval pulse
            state_next.tick     = 1'b1;
            state_next.tick_cnt = tick_load;
        end else begin
            // A new select takes hold at the next reload
            state_next.tick_cnt = state_reg.tick_cnt - 21'h00_0001;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RST_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bus outputs
    assign prdata  = state_reg.rdata;
    assign pready  = state_reg.ready;
    assign pslverr = state_reg.slverr;

    // Per-port fields, all straight from stored words
    for (genvar p = 0; p < 6; p++) begin : g_port
        // [RQ1] tagged-only admission bit
        assign admit_tagged_only[p]   = state_reg.regs[R_Q3W][p];
        // [RQ2] port VLAN fallback
        assign revert_to_port_vlan[p] = state_reg.regs[R_Q3W][6 + p];
        // [RQ7] egress tag bypass
        assign egress_tag_skip_enable[p] =
            state_reg.regs[R_SKIP][`SVBC_F_TAGSKIP_LO + p];
        // [RQ16] low limit nibbles
        assign rx_limit_low[p] = (p < 4) ?
            state_reg.regs[R_BW0][4*(p%4) +: 4] :
            state_reg.regs[R_BW1][4*(p%4) +: 4];
    end

    // [RQ4] upper VID bits per port
    assign port_vid_upper[0] = state_reg.regs[1][7:0];
    assign port_vid_upper[1] = state_reg.regs[R_TMR][7:0];
    assign port_vid_upper[2] = state_reg.regs[R_SKIP][7:0];
    assign port_vid_upper[3] = state_reg.regs[4][7:0];
    assign port_vid_upper[4] = state_reg.regs[4][15:8];
    assign port_vid_upper[5] = state_reg.regs[R_MC][7:0];

    // [RQ16] transmit low nibbles, ports 0 and 1
    assign tx_limit_low[0] = state_reg.regs[R_BW1][11:8];
    assign tx_limit_low[1] = state_reg.regs[R_BW1][15:12];

    // [RQ3] queue three weight
    assign queue_three_weight = state_reg.regs[R_Q3W][15:12];
    // [RQ5] timer select code
    assign rate_timer_select  =
        state_reg.regs[R_TMR][`SVBC_F_TIMER_LO +: 2];
    // [RQ6] back pressure exit
    assign backpressure_exit_select =
        state_reg.regs[R_TMR][`SVBC_F_BP_EXIT];
    // [RQ8] reserved multicast actions
    assign reserved_mcast_action =
        state_reg.regs[R_MC][`SVBC_F_MCAST_LO +: 4];
    // [RQ9] chip ID check control
    assign chip_id_check_disable =
        state_reg.regs[R_PHY][`SVBC_F_CHIPID_DIS];
    // [RQ10] special tag match value
    assign special_tag_ethertype = state_reg.regs[R_ET];
    // [RQ11] one-cycle restart pulse
    assign phy_restart = state_reg.restart;

    // LED and MAC options
    assign port4_led_mode = state_reg.regs[R_MISC][`SVBC_F_P4_LED];
    // [RQ12] dual speed hub LEDs
    assign dual_speed_hub_led_enable =
        state_reg.regs[R_MISC][`SVBC_F_DUAL_LED];
    // [RQ13] drop PAUSE violators
    assign drop_unpaced_frames = state_reg.regs[R_MISC][`SVBC_F_DROP];
    // [RQ14] tag processing bypass
    assign tag_bypass_enable =
        state_reg.regs[R_MISC][`SVBC_F_TAG_BYPASS];
    // [RQ15] clone width select
    assign mac_clone_width_select =
        state_reg.regs[R_MISC][`SVBC_F_CLONE_W];
    // [RQ17] port four clock invert
    assign invert_port4_pcs_clock =
        state_reg.regs[R_BWE][`SVBC_F_P4_CLK_INV];
    assign carrier_length_check_on = state_reg.crs_on;

    // Bandwidth control outputs
    assign new_rate_limit_enable =
        state_reg.regs[R_BWE][`SVBC_F_NEW_RATE_EN];
    assign rx_limit_enable = state_reg.rx_en;
    assign tx_limit_enable = state_reg.tx_en;
    assign rate_tick       = state_reg.tick;
    assign rate_step_kbps  = state_reg.step;

endmodule

// ===== verif/svbc_regs_properties.sv
// Purpose: Port-level checks of the configuration bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the bank at the foot
`timescale 1ns/100ps
module svbc_regs_properties (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Watched outputs
    input wire logic        phy_restart,
    input wire logic        carrier_length_check_on,
    input wire logic [1:0]  rate_timer_select,
    input wire logic        new_rate_limit_enable,
    input wire logic [5:0]  rx_limit_enable,
    input wire logic [5:0]  tx_limit_enable,
    input wire logic        rate_tick,
    input wire logic [9:0]  rate_step_kbps
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Accepted write; refused ones must leave state alone
    wire logic wr_ok;
    assign wr_ok = psel & penable & pready & pwrite & ~pslverr;

    // Step per timer code, spelled out from the rate table
    function automatic logic [9:0] step_of(input logic [1:0] s);
        case (s)
            2'h0: return 10'h040;
            2'h1: return 10'h200;
            2'h2: return 10'h0C8;
            default: return 10'h010;
        endcase
    endfunction

    ready_one_cycle_a: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");
    no_read_data_a: assert property (
        pready && (pwrite || pslverr) |-> prdata == 32'h0)
        else $error("read data on a write or refused access");
    restart_pulse_a: assert property (
        wr_ok && paddr == 12'h0BC |=> phy_restart ##1 !phy_restart)
        else $error("restart pulse missing or too long");
    crs_polarity_a: assert property (
        wr_ok && paddr == 12'h0CC && pstrb[1]
        |=> carrier_length_check_on == !$past(pwdata[14]))
        else $error("carrier length check polarity wrong");
    timer_select_a: assert property (
        wr_ok && paddr == 12'h0A4 && pstrb[1]
        |=> rate_timer_select == $past(pwdata[10:9]))
        else $error("timer select not taken from write");
    step_map_a: assert property (
        1'b1 |=> rate_step_kbps == step_of($past(rate_timer_select)))
        else $error("rate step does not follow select");
    enable_gate_a: assert property (
        (rx_limit_enable | tx_limit_enable) != 6'h0
        |-> new_rate_limit_enable)
        else $error("port limit active with global enable off");
    tick_gate_a: assert property (
        rate_tick |-> $past(new_rate_limit_enable))
        else $error("rate tick while control disabled");
    tick_single_a: assert property (
        rate_tick |=> !rate_tick)
        else $error("rate tick longer than one cycle");
endmodule

bind svbc_regs svbc_regs_properties svbc_regs_properties_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .phy_restart, .carrier_length_check_on,
    .rate_timer_select, .new_rate_limit_enable, .rx_limit_enable,
    .tx_limit_enable, .rate_tick, .rate_step_kbps
);

// ===== verif/tb.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: APB master on pclk, short rate intervals
// Notes:   A shadow of the 13 words predicts every output but restart, tick and step
`timescale 1ns/100ps
module tb;
    localparam int C8 = 20, C1 = 10, C40 = 4, C500 = 8;
    logic            pclk, presetn, psel, penable, pwrite;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata;
    logic [3:0]      pstrb, queue_three_weight, reserved_mcast_action;
    logic            pready, pslverr, phy_restart, rate_tick;
    logic [5:0]      admit_tagged_only, revert_to_port_vlan;
    logic [5:0][7:0] port_vid_upper;
    logic [5:0]      egress_tag_skip_enable, rx_limit_enable;
    logic [5:0]      tx_limit_enable;
    logic [15:0]     special_tag_ethertype;
    logic            backpressure_exit_select, chip_id_check_disable;
    logic            port4_led_mode, dual_speed_hub_led_enable;
    logic            drop_unpaced_frames, tag_bypass_enable;
    logic            mac_clone_width_select, invert_port4_pcs_clock;
    logic            carrier_length_check_on, new_rate_limit_enable;
    logic [1:0]      rate_timer_select;
    logic [5:0][3:0] rx_limit_low;
    logic [1:0][3:0] tx_limit_low;
    logic [9:0]      rate_step_kbps;
    int              num_errors, compares, restarts_seen, restarts_exp;
    logic [15:0]     sh [13];  // Shadow of words 0x27..0x33

    svbc_regs #(.CYC_8MS(C8), .CYC_1MS(C1), .CYC_40US(C40),
        .CYC_500US(C500)) svbc_regs_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .admit_tagged_only,
        .revert_to_port_vlan, .queue_three_weight, .port_vid_upper,
        .egress_tag_skip_enable, .reserved_mcast_action,
        .special_tag_ethertype, .backpressure_exit_select,
        .chip_id_check_disable, .phy_restart, .port4_led_mode,
        .dual_speed_hub_led_enable, .drop_unpaced_frames,
        .tag_bypass_enable, .mac_clone_width_select,
        .invert_port4_pcs_clock, .carrier_length_check_on,
        .rate_timer_select, .new_rate_limit_enable, .rx_limit_low,
        .tx_limit_low, .rx_limit_enable, .tx_limit_enable, .rate_tick,
        .rate_step_kbps);

    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Count restart pulses as they stand
    always @(posedge pclk) begin
        if (phy_restart === 1'b1) restarts_seen++;
    end

    // Hang guard, well past the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        print_verdict();
    end

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch word at %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_field(input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch field at %0t exp %h got %h", $time, e, g);
        end
    endtask

    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write word i, junk in the ignored upper half
    task automatic wr(input int i, input logic [15:0] v,
        input logic [3:0] s);
        logic [31:0] rd;
        logic        er;
        apb(12'(4 * (39 + i)), 1'b1, {16'hA5A5, v}, s, rd, er);
        if (s[0]) sh[i][7:0] = v[7:0];
        if (s[1]) sh[i][15:8] = v[15:8];
        if (i == 8) restarts_exp++;
        cmp_field(64'h0, 64'(er));
    endtask

    task automatic rdchk(input int i);
        logic [31:0] rd;
        logic        er;
        apb(12'(4 * (39 + i)), 1'b0, 32'h0, 4'h0, rd, er);
        cmp_word({16'h0, sh[i]}, rd);
    endtask

    // Every output but phy_restart, rate_tick and rate_step_kbps against the shadow
    task automatic chk_out();
        @(negedge pclk);
        cmp_field(64'(sh[0]), 64'({queue_three_weight,
            revert_to_port_vlan, admit_tagged_only}));
        cmp_field(64'({sh[5][7:0], sh[4], sh[3][7:0], sh[2][7:0],
            sh[1][7:0]}), 64'(port_vid_upper));
        cmp_field(64'({sh[3][13:8], sh[5][15:12], sh[7]}),
            64'({egress_tag_skip_enable, reserved_mcast_action,
            special_tag_ethertype}));
        cmp_field(64'({sh[2][10:8], sh[6][15]}), 64'({
            rate_timer_select, backpressure_exit_select,
            chip_id_check_disable}));
        cmp_field(64'({sh[9][12], sh[9][9:7], sh[9][5]}),
            64'({port4_led_mode, dual_speed_hub_led_enable,
            drop_unpaced_frames, tag_bypass_enable,
            mac_clone_width_select}));
        cmp_field(64'({sh[12][15], ~sh[12][14], sh[12][12]}),
            64'({invert_port4_pcs_clock, carrier_length_check_on,
            new_rate_limit_enable}));
        cmp_field(64'({sh[11], sh[10]}),
            64'({tx_limit_low, rx_limit_low}));
        cmp_field(64'({sh[12][11:9], sh[12][5], sh[12][3], sh[12][1],
            sh[12][8:6], sh[12][4], sh[12][2], sh[12][0]}
            & {12{sh[12][12]}}),
            64'({tx_limit_enable, rx_limit_enable}));
    endtask

    function automatic logic [15:0] rst_val(input int i);
        case (i)
            0: return 16'h1000;
            3: return 16'h3F00;
            5: return 16'hD000;
            6: return 16'h4442;
            9: return 16'h0987;
            default: return 16'h0000;
        endcase
    endfunction

    initial begin
        logic [31:0] rd, seed;
        logic        er;
        int          n;
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        for (int i = 0; i < 13; i++) sh[i] = rst_val(i);
        seed = $urandom(16058);
        repeat (10) @(posedge pclk);
        chk_out();
        cmp_field(64'({2'b01, 10'h040}), 64'({rate_tick,
            carrier_length_check_on, rate_step_kbps}));
        // Release on a rising edge, like every other input
        @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++) rdchk(i);
        $display("test reset values done");
        repeat (6) begin
            for (int i = 0; i < 13; i++) begin
                wr(i, 16'($urandom), 4'($urandom) | 4'h3);
            end
            chk_out();
            for (int i = 0; i < 13; i++) rdchk(i);
        end
        cmp_word(32'(restarts_exp), 32'(restarts_seen));
        wr(7, 16'hFFFF, 4'hF);
        wr(7, 16'h1234, 4'hD);
        rdchk(7);
        $display("test random and strobes done");
        for (int k = 0; k < 4; k++) begin
            logic [11:0] a;
            a = (k == 0) ? 12'h098 : (k == 1) ? 12'h0D0 :
                (k == 2) ? 12'h09E : 12'hFFC;
            apb(a, 1'b1, 32'h0000FFFF, 4'hF, rd, er);
            cmp_field(64'h1, 64'(er));
            apb(a, 1'b0, 32'h0, 4'h0, rd, er);
            cmp_word(32'h0, rd);
        end
        rdchk(0);
        rdchk(12);
        $display("test refused accesses done");
        wr(12, 16'h0FFF, 4'h3);
        chk_out();
        wr(12, 16'h1000, 4'h3);
        for (int c = 0; c < 4; c++) begin
            wr(2, {5'h0, 2'(c), 9'h0}, 4'h3);
            repeat (2) @(negedge pclk);
            cmp_field(64'((c == 0) ? 10'h040 : (c == 1) ? 10'h200 :
                (c == 2) ? 10'h0C8 : 10'h010), 64'(rate_step_kbps));
            repeat (2) begin
                n = 0;
                do begin
                    @(posedge pclk);
                    n++;
                end while (rate_tick !== 1'b1 && n < 100);
            end
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (rate_tick !== 1'b1 && n < 100);
            cmp_word(32'((c == 0) ? C8 : (c == 1) ? C1 :
                (c == 2) ? C40 : C500), 32'(n));
        end
        chk_out();
        $display("test rate timer done");
        print_verdict();
    end
endmodule
